// [src/fsbdc_defines.svh]
// constants for the front-side bus data-phase control block
`ifndef FSBDC_DEFINES_SVH
`define FSBDC_DEFINES_SVH
`define FSBDC_DATA_W 64
`define FSBDC_GROUP_W 16
`define FSBDC_GROUPS 4
`define FSBDC_BEATS 4
`define FSBDC_INVERT_LIMIT 5'h08
`define FSBDC_PARITY_ODD 1'b0
`endif

// [src/fsbdc_pkg.sv]
// types for the front-side bus data-phase control block
package fsbdc_pkg;
	typedef enum logic [1:0] {
		FSBDC_IDLE = 2'b00,
		FSBDC_DRIVE = 2'b01,
		FSBDC_DONE = 2'b10
	} fsbdc_state_type;
endpackage

// [src/fsbdc_data_ctrl.sv]
// data-phase control: inversion, parity, busy, strobes, capture
`timescale 1ns/10ps
`include "fsbdc_defines.svh"
module fsbdc_data_ctrl
	import fsbdc_pkg::*;
(
	// clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// core transmit side
	input wire logic tx_start,
	input wire logic [63:0] tx_data,
	input wire logic tx_beat_valid,
	input wire logic tx_invert_en,
	output logic tx_beat_taken,
	output logic tx_done,
	// core receive side
	output logic [63:0] rx_data,
	output logic rx_valid,
	output logic [3:0] rx_parity_err,
	output logic completion_n_a_seen,
	output logic bus_free,
	// bus pins, active low; output enables active high
	input wire logic [63:0] data_in_n,
	output logic [63:0] data_out_n,
	output logic data_oe,
	input wire logic [3:0] group_invert_in_n,
	output logic [3:0] group_invert_n,
	input wire logic [3:0] data_parity_in_n,
	output logic [3:0] data_parity_n,
	input wire logic data_bus_busy_in_n,
	output logic data_bus_busy_n,
	output logic data_bus_busy_oe,
	input wire logic data_valid_in_n,
	output logic data_valid_n,
	input wire logic completion_n_a,
	input wire logic [3:0] data_strobe_pos_in_n,
	input wire logic [3:0] data_strobe_neg_in_n,
	output logic [3:0] data_strobe_pos_n,
	output logic [3:0] data_strobe_neg_n,
	output logic strobe_oe
);

	// ----------------------------------------
	// group functions
	// ----------------------------------------
	function automatic logic [4:0] low_count(input logic [15:0] g);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 0; i < 16; i++)
			c = c + {4'h0, g[i]};
		return c;
	endfunction

	function automatic logic group_parity(input logic [15:0] g, input logic inv);
		return ^{g, inv} ^ `FSBDC_PARITY_ODD;
	endfunction

	// ----------------------------------------
	// transmit encode
	// ----------------------------------------
	fsbdc_state_type state;
	fsbdc_state_type next_state;
	logic [1:0] beat;
	logic [3:0] next_inv;
	logic [63:0] next_bus;
	logic [3:0] next_par;
	logic [3:0] stb_phase;
	logic [3:0] stb_phase_neg;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_tx
			// a logical 1 on the bus is an electrical low
			assign next_inv[gi] = tx_invert_en
				&& (low_count(tx_data[16*gi+:16]) > `FSBDC_INVERT_LIMIT);
			assign next_bus[16*gi+:16] = next_inv[gi] ? ~tx_data[16*gi+:16]
				: tx_data[16*gi+:16];
			assign next_par[gi] = group_parity(next_bus[16*gi+:16], next_inv[gi]);
		end
	endgenerate

	wire other_busy = ~data_bus_busy_in_n;
	wire start_ok = tx_start && !other_busy;
	wire beat_go = (state == FSBDC_DRIVE) && tx_beat_valid;
	// last beat still stands on the pins during done, so ownership lasts through it
	wire drive_on = (next_state == FSBDC_DRIVE) || (next_state == FSBDC_DONE);

	always_comb
	begin
		case (state)
			FSBDC_IDLE: next_state = start_ok ? FSBDC_DRIVE : FSBDC_IDLE;
			FSBDC_DRIVE: next_state = (beat_go && beat == 2'h3) ? FSBDC_DONE : FSBDC_DRIVE;
			FSBDC_DONE: next_state = FSBDC_IDLE;
			default: next_state = FSBDC_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= FSBDC_IDLE;
			beat <= 2'h0;
			data_out_n <= 64'h0000000000000000;
			group_invert_n <= 4'hF;
			data_parity_n <= 4'hF;
			data_oe <= 1'b0;
			data_bus_busy_n <= 1'b1;
			data_bus_busy_oe <= 1'b0;
			data_valid_n <= 1'b1;
			stb_phase <= 4'h0;
			stb_phase_neg <= 4'hF;
			strobe_oe <= 1'b0;
			tx_beat_taken <= 1'b0;
			tx_done <= 1'b0;
		end
		else
		begin
			state <= next_state;
			tx_beat_taken <= beat_go;
			tx_done <= (state == FSBDC_DONE);
			data_bus_busy_n <= !drive_on;
			data_bus_busy_oe <= drive_on;
			data_oe <= drive_on;
			strobe_oe <= drive_on;
			data_valid_n <= !beat_go;
			if (beat_go)
			begin
				beat <= beat + 2'h1;
				data_out_n <= ~next_bus;
				group_invert_n <= ~next_inv;
				data_parity_n <= ~next_par;
				stb_phase <= ~stb_phase;
				stb_phase_neg <= ~stb_phase_neg;
			end
			if (state == FSBDC_IDLE)
				beat <= 2'h0;
		end
	end

	assign data_strobe_pos_n = stb_phase;
	assign data_strobe_neg_n = stb_phase_neg;

	// ----------------------------------------
	// receive decode
	// ----------------------------------------
	logic [3:0] pos_q;
	logic [3:0] neg_q;
	wire [63:0] raw = ~data_in_n;
	wire [3:0] rx_inv = ~group_invert_in_n;
	wire [3:0] strobe_fall = (pos_q & ~data_strobe_pos_in_n) | (neg_q & ~data_strobe_neg_in_n);
	wire [63:0] restored;
	wire [3:0] rx_par;

	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_rx
			assign restored[16*gi+:16] = rx_inv[gi] ? ~raw[16*gi+:16]
				: raw[16*gi+:16];
			assign rx_par[gi] = group_parity(raw[16*gi+:16], rx_inv[gi]);
		end
	endgenerate

	wire rx_take = (state == FSBDC_IDLE) && !data_valid_in_n && (|strobe_fall);

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pos_q <= 4'hF;
			neg_q <= 4'hF;
			rx_data <= 64'h0000000000000000;
			rx_valid <= 1'b0;
			rx_parity_err <= 4'h0;
			completion_n_a_seen <= 1'b0;
			bus_free <= 1'b0;
		end
		else
		begin
			pos_q <= data_strobe_pos_in_n;
			neg_q <= data_strobe_neg_in_n;
			rx_valid <= rx_take;
			completion_n_a_seen <= !completion_n_a;
			bus_free <= data_bus_busy_in_n && (state == FSBDC_IDLE);
			if (rx_take)
			begin
				rx_data <= restored;
				rx_parity_err <= rx_par ^ ~data_parity_in_n;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_beat;
		beat_go;
	endsequence

	a_busy_while_drive: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == FSBDC_DRIVE || state == FSBDC_DONE) |-> !data_bus_busy_n && data_bus_busy_oe)
		else $error("busy not driven while owning bus");
	a_valid_per_beat: assert property (@(posedge mclk) disable iff (!arst_n)
		s_beat |=> !data_valid_n)
		else $error("data valid missing after beat");
	a_invert_limit: assert property (@(posedge mclk) disable iff (!arst_n)
		s_beat |=> (group_invert_n[0] || ($past(low_count(tx_data[15:0])) > 5'h08)))
		else $error("group inverted without majority");
	a_invert_off: assert property (@(posedge mclk) disable iff (!arst_n)
		(beat_go && !tx_invert_en) |=> group_invert_n == 4'hF)
		else $error("group inverted while inversion disabled");
	a_parity_match: assert property (@(posedge mclk) disable iff (!arst_n)
		s_beat |=> data_parity_n[0] == ~(^{~data_out_n[15:0], ~group_invert_n[0]}))
		else $error("parity does not cover group");
	a_start_free: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == FSBDC_IDLE && tx_start && !data_bus_busy_in_n) |=> state == FSBDC_IDLE)
		else $error("started while bus busy");
	a_completion_n_a_sampled: assert property (@(posedge mclk) disable iff (!arst_n)
		!completion_n_a |=> completion_n_a_seen)
		else $error("completion_n_a not sampled");
	a_rx_restore: assert property (@(posedge mclk) disable iff (!arst_n)
		rx_take && rx_inv[1] |=> rx_data[31:16] == $past(data_in_n[31:16]))
		else $error("inverted group not restored");
	a_strobe_toggle: assert property (@(posedge mclk) disable iff (!arst_n)
		s_beat |=> data_strobe_pos_n != $past(data_strobe_pos_n))
		else $error("strobe did not toggle on beat");
	a_oe_follow: assert property (@(posedge mclk) disable iff (!arst_n)
		data_oe == data_bus_busy_oe)
		else $error("data driven without bus ownership");
	a_busy_release: assert property (@(posedge mclk) disable iff (!arst_n)
		(state == FSBDC_DONE) |=> data_bus_busy_n && !data_oe)
		else $error("busy held after done");

endmodule // fsbdc_data_ctrl

// [test/fsbdc_agent_model.sv]
// chipset-side bus agent model driving the receive pins
`timescale 1ns/10ps
module fsbdc_agent_model (
	// clock
	input wire logic mclk,
	// bus pins toward the block, active low
	output logic [63:0] d_n,
	output logic [3:0] inv_n,
	output logic [3:0] par_n,
	output logic [3:0] stb_n,
	output logic busy_n,
	output logic valid_n,
	output logic completion_n_a_n
);
	logic [15:0] g;
	initial
	begin
		{d_n, inv_n, par_n, stb_n, busy_n, valid_n, completion_n_a_n} = '1;
	end
	task automatic control(input logic b, input logic f);
		@(negedge mclk);
		busy_n = b;
		completion_n_a_n = f;
	endtask
	task automatic send(input logic [63:0] d);
		@(negedge mclk);
		busy_n = 1'b0;
		valid_n = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			g = d[16*i +: 16];
			inv_n[i] = ($countones(g) <= 8);
			d_n[16*i +: 16] = inv_n[i] ? ~g : g;
			par_n[i] = ^{d_n[16*i +: 16], inv_n[i]};
		end
		@(negedge mclk);
		stb_n = 4'h0;
		@(negedge mclk);
		// released lines show the inverse of the last value
		{d_n, inv_n, par_n} = ~{d_n, inv_n, par_n};
		{stb_n, busy_n, valid_n} = '1;
	endtask
endmodule // fsbdc_agent_model

// [test/fsb_data_bus_control_bench.sv]
// self-checking bench for the bus data-phase control block
`timescale 1ns/10ps
module fsb_data_bus_control_bench;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic tx_start = 1'b0;
	logic tx_beat_valid = 1'b0;
	logic tx_invert_en = 1'b1;
	logic busy_oe, stb_oe;
	logic [3:0] stb_pos, stb_neg;
	logic [63:0] tx_data = 64'h0;
	logic tx_beat_taken, tx_done, rx_valid, completion_n_a_seen, bus_free, data_oe, busy_n, valid_n;
	logic busy_in_n, valid_in_n, completion_n_a_n;
	logic [63:0] rx_data, data_out_n, d_n;
	logic [3:0] rx_parity_err, group_invert_n, data_parity_n, inv_n, par_n, stb_n;
	int n_mismatch = 0;
	int cmp_count = 0;
	always #2.5 mclk = ~mclk;
	fsbdc_data_ctrl fsbdc_data_ctrl_i (.mclk(mclk), .arst_n(arst_n), .tx_start(tx_start),
		.tx_data(tx_data), .tx_beat_valid(tx_beat_valid), .tx_invert_en(tx_invert_en),
		.tx_beat_taken(tx_beat_taken), .tx_done(tx_done), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_parity_err(rx_parity_err), .completion_n_a_seen(completion_n_a_seen), .bus_free(bus_free),
		.data_in_n(d_n), .data_out_n(data_out_n), .data_oe(data_oe), .group_invert_in_n(inv_n),
		.group_invert_n(group_invert_n), .data_parity_in_n(par_n), .data_parity_n(data_parity_n),
		.data_bus_busy_in_n(busy_in_n), .data_bus_busy_n(busy_n), .data_bus_busy_oe(busy_oe),
		.data_valid_in_n(valid_in_n), .data_valid_n(valid_n), .completion_n_a(completion_n_a_n),
		.data_strobe_pos_in_n(stb_n), .data_strobe_neg_in_n(stb_n), .data_strobe_pos_n(stb_pos),
		.data_strobe_neg_n(stb_neg), .strobe_oe(stb_oe));
	fsbdc_agent_model fsbdc_agent_model_i (.mclk(mclk), .d_n(d_n), .inv_n(inv_n), .par_n(par_n),
		.stb_n(stb_n), .busy_n(busy_in_n), .valid_n(valid_in_n), .completion_n_a_n(completion_n_a_n));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	task automatic test_send(input logic en);
		logic [63:0] beat [4];
		logic [15:0] g;
		logic [15:0] exp_g;
		logic [3:0] last_stb;
		logic inv;
		int n;
		beat = '{64'h00FF_FFFF_0000_01FF, 64'h0000_1234_FFFF_00FF, 64'hFFF0_8001_00FF_FE00,
			64'h0001_7FFF_C000_FFFF};
		tx_invert_en = en;
		tx_start = 1'b1;
		@(negedge mclk);
		tx_start = 1'b0;
		chk(64'(busy_n), 64'h0, "busy");
		chk(64'(data_oe), 64'h1, "oe");
		chk(64'({busy_oe, stb_oe}), 64'h3, "busy and strobe enables");
		last_stb = stb_pos;
		tx_beat_valid = 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			tx_data = beat[k];
			n = 0;
			do
			begin
				@(negedge mclk);
				n++;
			end while (tx_beat_taken !== 1'b1 && n < 8);
			chk(64'(tx_beat_taken), 64'h1, "beat taken");
			for (int i = 0; i < 4; i++)
			begin
				g = beat[k][16*i +: 16];
				inv = en && ($countones(g) > 8);
				exp_g = inv ? g : ~g;
				chk(64'(group_invert_n[i]), 64'(!inv), "flag");
				chk(64'(data_out_n[16*i +: 16]), 64'(exp_g), "data");
				chk(64'(^{data_out_n[16*i +: 16], group_invert_n[i], data_parity_n[i]}), 64'h0,
					"parity");
			end
			chk(64'(stb_pos ^ last_stb), 64'hF, "strobe toggle");
			chk(64'(stb_neg ^ stb_pos), 64'hF, "strobe pair");
			last_stb = stb_pos;
			chk(64'(valid_n), 64'h0, "valid");
			chk(64'(busy_n), 64'h0, "busy held");
			chk(64'(data_oe), 64'h1, "oe held");
		end
		tx_beat_valid = 1'b0;
		@(negedge mclk);
		chk(64'({tx_done, busy_n}), 64'h3, "done");
		chk(64'({data_oe, busy_oe, stb_oe, valid_n}), 64'h1, "released");
		$display("send test done");
	endtask
	task automatic test_refuse;
		fsbdc_agent_model_i.control(1'b0, 1'b1);
		tx_start = 1'b1;
		repeat (3) @(negedge mclk);
		tx_start = 1'b0;
		chk(64'({busy_n, bus_free}), 64'h2, "start while busy");
		fsbdc_agent_model_i.control(1'b1, 1'b1);
		@(negedge mclk);
		chk(64'(bus_free), 64'h1, "free");
		$display("refuse test done");
	endtask
	task automatic test_receive;
		int n;
		n = 0;
		fork
			fsbdc_agent_model_i.send(64'h00FF_FFFF_0000_01FF);
			do
			begin
				@(negedge mclk);
				n++;
			end while (rx_valid !== 1'b1 && n < 8);
		join
		chk(64'(rx_valid), 64'h1, "rx valid");
		chk(rx_data, 64'h00FF_FFFF_0000_01FF, "rx data");
		chk(64'(rx_parity_err), 64'h0, "rx parity");
		$display("receive test done");
	endtask
	task automatic test_completion_n_a;
		fsbdc_agent_model_i.control(1'b1, 1'b0);
		repeat (2) @(negedge mclk);
		chk(64'(completion_n_a_seen), 64'h1, "completion_n_a");
		fsbdc_agent_model_i.control(1'b1, 1'b1);
		repeat (2) @(negedge mclk);
		chk(64'(completion_n_a_seen), 64'h0, "no completion_n_a");
		$display("completion_n_a test done");
	endtask
	initial
	begin
		repeat (6) @(negedge mclk);
		arst_n = 1'b1;
		test_send(1'b1);
		test_send(1'b0);
		test_refuse();
		test_receive();
		test_completion_n_a();
		report_and_stop();
	end
	initial
	begin
		#2000;
		n_mismatch++;
		report_and_stop();
	end
endmodule // fsb_data_bus_control_bench
